// >>> core/tof_i2c_target.v
// i2c target port with sequentially addressed storage
// Contract
// [R1] the port answers only when the received 7-bit address equals 0x5C.
// [R2] after a start the host sends seven address bits then a direction bit, msb first.
// [R3] direction 0 means host writes, direction 1 means host reads.
// [R4] sda falling while scl high is a start and readies the port for a new transfer.
// [R5] sda rising while scl high is a stop and ends the transfer.
// [R6] sda changes only while scl low and is sampled on scl high, one bit per period.
// [R7] after eight bits the transmitter releases sda and the receiver pulls it low in the ninth.
// [R8] sda not low during the ninth high phase is a not-acknowledge that fails the transfer.
// [R9] sda is released at the end of the ninth clock or when the transfer ends.
// [R10] a write carries a word address and then data bytes to store.
// [R11] the port holds sequential storage units and a pointer loaded from the word address.
// [R12] a read is a dummy write of the word address, a repeated start, then read direction.
// [R13] scl from standstill up to 1 MHz is handled.
// [R14] spikes of at most 50 ns on scl and sda are filtered before detection.
// [R15] on an address mismatch sda stays released until the next start.
// [R16] a repeated start restarts address reception and keeps the pointer.
`timescale 1ns/1ps
`include "tof_i2c_target_regs.vh"
module tof_i2c_target #(
  parameter MEM_DEPTH = 256,
  parameter PTR_W = 8
) (
  input wire clk_sys,
  input wire reset_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output reg [PTR_W-1:0] ptr_ff,
  output reg busy_ff,
  output reg nack_ff
);
  // ============================================================
  // states
  localparam ST_IDLE = 6'b000001;
  localparam ST_ADDR = 6'b000010;
  localparam ST_RX = 6'b000100;
  localparam ST_TX = 6'b001000;
  localparam ST_ACK = 6'b010000;
  localparam ST_RACK = 6'b100000;

  // ============================================================
  // filtered lines and engine state
  wire scl_f;
  wire sda_f;
  reg scl_d_ff;
  reg sda_d_ff;
  reg [5:0] state_ff;
  reg [3:0] bit_ff;
  reg [7:0] shift_ff;
  reg drive_low_ff;
  reg is_read_ff;
  reg have_ptr_ff;
  reg ack_mine_ff;
  reg [7:0] mem_ff [0:MEM_DEPTH-1];
  integer i;

  glitch_filter #(.SPIKE_CYC(`TGT_SPIKE_CYC)) u_scl_filter ( // R14
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(scl_in),
    .line_out_ff(scl_f)
  );
  glitch_filter #(.SPIKE_CYC(`TGT_SPIKE_CYC)) u_sda_filter ( // R14
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .line_in(sda_in),
    .line_out_ff(sda_f)
  );

  // ============================================================
  // bus events; oversampling at 125 MHz covers any scl up to 1 MHz
  wire scl_rise = scl_f & ~scl_d_ff; // R13
  wire scl_fall = ~scl_f & scl_d_ff; // R6
  wire start_ev = scl_f & scl_d_ff & sda_d_ff & ~sda_f; // R4
  wire stop_ev = scl_f & scl_d_ff & ~sda_d_ff & sda_f; // R5

  // ============================================================
  // pad drive
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_ff;

  // ============================================================
  // helpers
  // pointer wraps at the top of storage so long bursts never stall
  function [PTR_W-1:0] ptr_inc;
    input [PTR_W-1:0] p;
    begin
      ptr_inc = (p == MEM_DEPTH - 1) ? {PTR_W{1'b0}} : p + 1'b1; // R11
    end
  endfunction

  // a zero bit is sent by pulling; a one bit leaves the line to the pull-up
  function msb_pull;
    input [7:0] b;
    begin
      msb_pull = ~b[7];
    end
  endfunction

  // ============================================================
  // protocol engine
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      state_ff <= ST_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= 8'h00;
      drive_low_ff <= 1'b0;
      is_read_ff <= 1'b0;
      have_ptr_ff <= 1'b0;
      ack_mine_ff <= 1'b0;
      ptr_ff <= {PTR_W{1'b0}};
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      for (i = 0; i < MEM_DEPTH; i = i + 1) begin
        mem_ff[i] <= `TGT_MEM_RESET;
      end
    end else begin
      scl_d_ff <= scl_f;
      sda_d_ff <= sda_f;
      if (start_ev) begin
        // repeated start keeps the pointer
        state_ff <= ST_ADDR; // R4 R16
        bit_ff <= 4'h0;
        drive_low_ff <= 1'b0;
        busy_ff <= 1'b1;
        nack_ff <= 1'b0;
      end else if (stop_ev) begin
        state_ff <= ST_IDLE; // R5
        drive_low_ff <= 1'b0; // R9
        busy_ff <= 1'b0;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            // foreign address or host refusal parks here; only a start leaves
            drive_low_ff <= 1'b0; // R15
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], sda_f}; // R2 R6
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              bit_ff <= 4'h0;
              if (state_ff == ST_ADDR) begin
                if (shift_ff[7:1] == `TGT_DEV_ADDR) begin // R1
                  is_read_ff <= (shift_ff[0] == `TGT_DIR_READ); // R3
                  have_ptr_ff <= 1'b0;
                  drive_low_ff <= 1'b1; // R7
                  state_ff <= ST_ACK;
                end else begin
                  state_ff <= ST_IDLE; // R15
                  busy_ff <= 1'b0;
                end
              end else begin
                // first byte after a write address is the word address, later ones data
                if (!have_ptr_ff) begin
                  ptr_ff <= shift_ff[PTR_W-1:0]; // R10 R11 R12
                  have_ptr_ff <= 1'b1;
                end else begin
                  mem_ff[ptr_ff] <= shift_ff; // R10
                  ptr_ff <= ptr_inc(ptr_ff);
                end
                drive_low_ff <= 1'b1; // R7
                state_ff <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // release on the falling edge that closes the ninth clock
            if (scl_fall) begin
              drive_low_ff <= 1'b0; // R9
              bit_ff <= 4'h0;
              if (is_read_ff) begin
                shift_ff <= mem_ff[ptr_ff]; // R12
                drive_low_ff <= msb_pull(mem_ff[ptr_ff]);
                state_ff <= ST_TX;
              end else begin
                state_ff <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall) begin
              if (bit_ff == 4'h8) begin
                drive_low_ff <= 1'b0; // R7
                ptr_ff <= ptr_inc(ptr_ff); // R11
                state_ff <= ST_RACK;
              end else begin
                shift_ff <= {shift_ff[6:0], 1'b0};
                drive_low_ff <= ~shift_ff[6]; // R6
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              // host must hold its answer through the high phase, so the rise is enough
              ack_mine_ff <= ~sda_f; // R8
            end else if (scl_fall) begin
              bit_ff <= 4'h0;
              if (ack_mine_ff) begin
                shift_ff <= mem_ff[ptr_ff];
                drive_low_ff <= msb_pull(mem_ff[ptr_ff]);
                state_ff <= ST_TX;
              end else begin
                // host declined: stay off the bus until stop or start
                nack_ff <= 1'b1; // R8
                state_ff <= ST_IDLE;
                busy_ff <= 1'b0;
              end
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // tof_i2c_target

// >>> core/tof_i2c_target_regs.vh
// constants of the ranging sensor i2c target port
`ifndef TOF_I2C_TARGET_REGS_VH
`define TOF_I2C_TARGET_REGS_VH
// ============================================================
// addressing
`define TGT_DEV_ADDR 7'h5C
`define TGT_DIR_WRITE 1'b0
`define TGT_DIR_READ 1'b1
// ============================================================
// timing
`define TGT_CLK_PERIOD_PS 8000
`define TGT_SPIKE_NS 50
// longest spike rounded down to whole cycles, 6 at 8000 ps
`define TGT_SPIKE_CYC ((`TGT_SPIKE_NS * 1000) / `TGT_CLK_PERIOD_PS)
// ============================================================
// storage reset value
`define TGT_MEM_RESET 8'h00
`endif

// >>> core/glitch_filter.v
// spike filter for one bus line
`timescale 1ns/1ps
module glitch_filter #(
  parameter SPIKE_CYC = 6
) (
  input wire clk_sys,
  input wire reset_n,
  input wire line_in,
  output reg line_out_ff
);
  reg [1:0] sync_ff;
  reg [3:0] cnt_ff;
  // ============================================================
  // level must hold longer than the spike width before it is accepted
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      sync_ff <= 2'h3;
      cnt_ff <= 4'h0;
      line_out_ff <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[0], line_in};
      if (sync_ff[1] == line_out_ff) begin
        cnt_ff <= 4'h0;
      end else if (cnt_ff >= SPIKE_CYC[3:0]) begin
        line_out_ff <= sync_ff[1];
        cnt_ff <= 4'h0;
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end
endmodule // glitch_filter

// >>> tb/i2c_host_model.sv
// behavioural i2c host driving the bus clock and data
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic sda_line,
  output logic scl,
  output logic sda_h
);
  // half period in ns; leaves room for the target's input filter latency
  localparam int T = 520;
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic start();
    sda_h = 1'b1;
    #T scl = 1'b1;
    #T sda_h = 1'b0;
    #T scl = 1'b0;
  endtask
  task automatic stop();
    sda_h = 1'b0;
    #T scl = 1'b1;
    #T sda_h = 1'b1;
    #T;
  endtask
  // eight bits msb first, then the acknowledge slot; data moves only with scl low
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_h = d[i];
      #T scl = 1'b1;
      #T q[i] = sda_line;
      scl = 1'b0;
    end
  endtask
  // short low pulse on data with the clock high, narrower than the target's filter
  task automatic glitch(input int w);
    sda_h = 1'b0;
    #w sda_h = 1'b1;
  endtask
endmodule // i2c_host_model

// >>> tb/tof_i2c_target_checker.sv
// assertion checker for the i2c target port
`timescale 1ns/1ps
module tof_i2c_target_checker #(parameter PTR_W = 8) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [PTR_W-1:0] ptr_ff,
  input wire logic busy_ff,
  input wire logic nack_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_pull;
    $fell(sda_oe_n);
  endsequence
  a_open_drain: assert property (sda_out == 1'b0) else $error("sda value not 0");
  a_reset_state: assert property ($rose(reset_n) |-> sda_oe_n && !busy_ff
    && !nack_ff && ptr_ff == '0) else $error("bad state after reset");
  a_idle_release: assert property (!busy_ff |-> sda_oe_n) else $error("sda held idle");
  a_change_low: assert property ($changed(sda_oe_n) |-> !scl_in) else $error("sda moved");
  a_nack_free: assert property (nack_ff |-> sda_oe_n) else $error("sda held after nack");
  a_start_seen: assert property ($rose(busy_ff) |-> scl_in && !sda_in) else $error("busy");
  a_ptr_moves: assert property ($changed(ptr_ff) |-> busy_ff && !scl_in) else $error("ptr");
  a_ack_held: assert property (s_pull |=> !sda_oe_n [*8]) else $error("pull too short");
endmodule // tof_i2c_target_checker
bind tof_i2c_target tof_i2c_target_checker #(.PTR_W(PTR_W)) u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .ptr_ff(ptr_ff), .busy_ff(busy_ff), .nack_ff(nack_ff));

// >>> tb/testbench.sv
// self-checking bench for the i2c target port
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic scl, sda_h, sda_out, sda_oe_n, busy_ff, nack_ff;
  logic [7:0] ptr_ff;
  logic [8:0] got;
  logic [8:0] exp_q[$];
  logic [7:0] mem[256];
  int failures = 0;
  int checks_done = 0;
  event seen;
  wire sda_w = sda_h & (sda_oe_n | sda_out);
  initial forever #4 clk_sys = ~clk_sys;
  i2c_host_model host (.sda_line(sda_w), .scl(scl), .sda_h(sda_h));
  tof_i2c_target DUT (.clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ptr_ff(ptr_ff), .busy_ff(busy_ff), .nack_ff(nack_ff));
  task automatic chk(input string what, input logic [8:0] s, input logic [8:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bus_byte(input logic [8:0] d, input logic [8:0] e);
    exp_q.push_back(e);
    host.xfer(d, got);
    ->seen;
  endtask
  initial forever begin
    @(seen);
    chk("bus byte", got, exp_q.pop_front());
  end
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
  // ============================================================
  // main sequence
  initial begin
    logic [7:0] w, b;
    logic spiked;
    void'($urandom(32'h8A5DA7D2));
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    w = 8'($urandom);
    host.start();
    bus_byte({7'h5C, 1'b0, 1'b1}, {7'h5C, 1'b0, 1'b0});
    bus_byte({w, 1'b1}, {w, 1'b0});
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      mem[8'(w + i)] = b;
      bus_byte({b, 1'b1}, {b, 1'b0});
    end
    host.stop();
    chk("pointer", {1'b0, ptr_ff}, {1'b0, 8'(w + 3)});
    chk("busy", {8'h00, busy_ff}, 9'h000);
    $display("test write done");
    host.start();
    bus_byte({7'h5C, 1'b0, 1'b1}, {7'h5C, 1'b0, 1'b0});
    bus_byte({w, 1'b1}, {w, 1'b0});
    host.start();
    bus_byte({7'h5C, 1'b1, 1'b1}, {7'h5C, 1'b1, 1'b0});
    for (int i = 0; i < 3; i++) bus_byte({8'hFF, i == 2}, {mem[8'(w + i)], i == 2});
    // the refusal is flagged only once the input filter has passed the falling clock
    repeat (20) @(posedge clk_sys);
    #1;
    chk("nack", {8'h00, nack_ff}, 9'h001);
    chk("busy after nack", {8'h00, busy_ff}, 9'h000);
    host.stop();
    $display("test read done");
    host.start();
    bus_byte({7'h5D, 1'b0, 1'b1}, {7'h5D, 1'b0, 1'b1});
    bus_byte({8'hA5, 1'b1}, {8'hA5, 1'b1});
    host.stop();
    chk("nack after start", {8'h00, nack_ff}, 9'h000);
    $display("test foreign address done");
    spiked = 1'b0;
    fork
      host.glitch(40);
      repeat (20) @(posedge clk_sys) spiked = spiked | busy_ff;
    join
    chk("busy after spike", {8'h00, spiked}, 9'h000);
    $display("test spike done");
    report_and_stop();
  end
endmodule // testbench
